// >>> mtpc_phy_model.sv
`timescale 1ns/10ps
// line side: ends every started data or pause frame after a programmable number of cycles
module mtpc_phy_model
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic        pause_i,
    input  wire logic [15:0] ptime_i,
    input  wire logic        bad_fcs_i,
    input  wire logic [7:0]  delay_i,
    output logic             done_o,
    output logic             busy_o,
    output int               starts_o,
    output int               pauses_o,
    output logic      [15:0] ptime_o,
    output logic             bad_o
);
    logic [7:0] left_q;

    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        if (!rst_n_i)
        begin
            busy_o   <= 1'b0;
            starts_o <= 0;
            pauses_o <= 0;
            ptime_o  <= 16'h0000;
            bad_o    <= 1'b0;
            left_q   <= 8'h00;
        end
        else if (busy_o)
        begin
            left_q <= left_q - 8'h01;
            if (left_q == 8'h00)
            begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
            end
        end
        else if (start_i || pause_i)
        begin
            // a request while busy would break the frame order, so it is not accepted here
            busy_o <= 1'b1;
            left_q <= delay_i;
            if (start_i)
            begin
                starts_o <= starts_o + 1;
                bad_o    <= bad_fcs_i;
            end
            else
            begin
                pauses_o <= pauses_o + 1;
                ptime_o  <= ptime_i;
            end
        end
    end
endmodule : mtpc_phy_model

// >>> mtpc_pkg.sv
package mtpc_pkg;
    // register byte addresses
    localparam logic [11:0] TXCTL_OFS = 12'h108;
    localparam logic [11:0] FLOW_OFS  = 12'h10C;
    localparam logic [11:0] SEED_OFS  = 12'h110;
    localparam logic [11:0] ISTS_OFS  = 12'h1F0;
    localparam logic [11:0] IMSK_OFS  = 12'h1F4;

    // field positions
    localparam int TRANSMITTER_ENABLE_BIT  = 0;
    localparam int TXD_BIT   = 1;
    localparam int CORRUPT_CHECKSUM_ENABLE_BIT  = 2;
    localparam int FPF_BIT   = 28;
    localparam int RXFC_BIT  = 29;
    localparam int TXFC_BIT  = 30;
    localparam int FORCE_BIT = 31;

    // interrupt status / mask layout
    localparam int IRQ_W     = 3;
    localparam int IRQ_TXD   = 0;
    localparam int IRQ_PSENT = 1;
    localparam int IRQ_PRCV  = 2;

    // reset values
    localparam logic [15:0] PTIME_RST = 16'h0000;
    localparam logic [15:0] SEED_RST  = 16'h9876;

    // one slot is 512 bit times; the nibble-wide line moves 4 bits per 40 ns clock
    localparam int SLOT_BITS     = 512;
    localparam int BITS_PER_CLK  = 4;
    localparam int SLOT_CYCLES   = SLOT_BITS / BITS_PER_CLK;
    localparam logic [6:0] SLOT_LAST = 7'(SLOT_CYCLES - 1);

    // receive fifo used space is counted in 512-byte blocks
    localparam int USED_SHIFT = 9;

    // back-off
    localparam logic [3:0]  BO_LIMIT    = 4'hA;
    localparam logic [4:0]  ATTEMPT_MAX = 5'h10;
    localparam logic [9:0]  BO_FULL     = 10'h3FF;

    typedef enum logic [1:0] {
        MT_IDLE  = 2'b00,
        MT_DATA  = 2'b01,
        MT_PAUSE = 2'b10
    } mtpc_state_t;
endpackage : mtpc_pkg

// >>> mtpc_top.sv
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
// Summary of operation
// - while the corrupt checksum bit is set every data frame sent gets a bad frame check sequence.
// - frames leave the buffer only while the transmitter enable bit is set.
// - clearing enable mid-frame lets that frame finish before the transmitter stops.
// - the disabled flag sets when a one-to-zero disable sequence completes; a write of one clears it.
// - with pause decode enabled a valid pause frame holds data transmission for quanta times slot time or up to one slot less.
// - with pause decode disabled no frame is decoded as control and no new pause is loaded; a hold already running counts out.
// - writing one to the manual pause request sends one pause frame, then the bit clears itself.
// - with auto pause enabled, used space over 512 at or above the on threshold sends a pause.
// - after that, used space over 512 at or below the off threshold sends a zero-time pause.
// - pause generation and reaction act only in full duplex.
// - the forward bit sinks received pause frames at zero and passes them on at one.
// - the 16-bit pause time value, reset to zero, fills manual and on-threshold pause frames.
// - the 16-bit seed, reset to 9876h, initialises the back-off shift register.
module mtpc_top
    import mtpc_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic [11:0] REG_ADDR_I,
    input  wire logic [31:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [31:0] REG_RDATA_O,
    input  wire logic        FULL_DUPLEX_I,
    input  wire logic        TXQ_VALID_I,
    input  wire logic        FRAME_DONE_I,
    input  wire logic        COLLISION_I,
    input  wire logic [15:0] RX_USED_I,
    input  wire logic [7:0]  FC_ON_THR_I,
    input  wire logic [7:0]  FC_OFF_THR_I,
    input  wire logic        RX_PAUSE_VALID_I,
    input  wire logic [15:0] RX_PAUSE_QUANTA_I,
    output logic             TXQ_START_O,
    output logic             BAD_FCS_O,
    output logic             PAUSE_SEND_O,
    output logic      [15:0] PAUSE_TIME_O,
    output logic             PAUSE_HOLD_O,
    output logic             RX_CTRL_DECODE_O,
    output logic             RX_PAUSE_FORWARD_O,
    output logic             IRQ_O
);
    mtpc_state_t       state_q, state_d;
    logic              transmitter_enable_q, transmitter_enable_d, corrupt_checksum_enable_q, corrupt_checksum_enable_d, txd_q, txd_d, dis_q, dis_d;
    logic              force_q, force_d, txfc_q, txfc_d, rxfc_q, rxfc_d, fpf_q, fpf_d;
    logic [15:0]       ptime_q, ptime_d, seed_q, seed_d, ptx_q, ptx_d;
    logic [IRQ_W-1:0]  ists_q, ists_d, imsk_q, imsk_d, ev;
    logic [31:0]       rdata_q, rdata_d;
    logic              start_q, start_d, psend_q, psend_d, bad_q, bad_d;
    logic              dec_q, dec_d, fwd_q, fwd_d, irq_q, irq_d;
    logic              hi_q, hi_d, apend_q, apend_d, azero_q, azero_d, pman_q, pman_d;
    logic [4:0]        attempt_q, attempt_d;
    logic              collide;
    logic [15:0]       lfsr_q, lfsr_d, quanta_q, quanta_d;
    logic [6:0]        tick_q, tick_d;
    logic [9:0]        bo_q, bo_d;
    logic              hold_q, hold_d;
    logic              wr_tx, wr_flow, wr_seed, slot_end, pause_load;
    logic [15:0]       used_blk;
    logic [3:0]        bo_exp;

    assign wr_tx      = REG_WR_I && REG_ADDR_I == TXCTL_OFS;
    assign wr_flow    = REG_WR_I && REG_ADDR_I == FLOW_OFS;
    assign wr_seed    = REG_WR_I && REG_ADDR_I == SEED_OFS;
    assign used_blk   = RX_USED_I >> USED_SHIFT;
    assign slot_end   = tick_q == 7'h00;
    // decode only while enabled and in full duplex
    assign pause_load = RX_PAUSE_VALID_I && rxfc_q && FULL_DUPLEX_I;

    // ---------------- registers, frame sequencing, flow control ----------------
    always_comb
    begin
        state_d   = state_q;
        transmitter_enable_d    = transmitter_enable_q;
        corrupt_checksum_enable_d    = corrupt_checksum_enable_q;
        txd_d     = txd_q;
        dis_d     = dis_q;
        force_d   = force_q;
        txfc_d    = txfc_q;
        rxfc_d    = rxfc_q;
        fpf_d     = fpf_q;
        ptime_d   = ptime_q;
        seed_d    = seed_q;
        imsk_d    = imsk_q;
        ists_d    = ists_q;
        ptx_d     = ptx_q;
        bad_d     = bad_q;
        hi_d      = hi_q;
        apend_d   = apend_q;
        azero_d   = azero_q;
        pman_d    = pman_q;
        attempt_d = attempt_q;
        rdata_d   = 32'h0000_0000;
        start_d   = 1'b0;
        psend_d   = 1'b0;
        collide   = 1'b0;
        ev        = '0;

        if (wr_tx)
        begin
            transmitter_enable_d = REG_WDATA_I[TRANSMITTER_ENABLE_BIT];
            corrupt_checksum_enable_d = REG_WDATA_I[CORRUPT_CHECKSUM_ENABLE_BIT];
            // a one-to-zero change starts the disabling sequence
            dis_d  = (transmitter_enable_q || dis_q) && !REG_WDATA_I[TRANSMITTER_ENABLE_BIT];
            if (REG_WDATA_I[TXD_BIT])
                txd_d = 1'b0;
        end
        if (wr_flow)
        begin
            txfc_d  = REG_WDATA_I[TXFC_BIT];
            rxfc_d  = REG_WDATA_I[RXFC_BIT];
            fpf_d   = REG_WDATA_I[FPF_BIT];
            ptime_d = REG_WDATA_I[15:0];
        end
        if (wr_seed)
            seed_d = REG_WDATA_I[15:0];
        if (REG_WR_I && REG_ADDR_I == IMSK_OFS)
            imsk_d = REG_WDATA_I[IRQ_W-1:0];

        if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                TXCTL_OFS: rdata_d = {29'h0, corrupt_checksum_enable_q, txd_q, transmitter_enable_q};
                FLOW_OFS:  rdata_d = {force_q, txfc_q, rxfc_q, fpf_q, 12'h000, ptime_q};
                SEED_OFS:  rdata_d = {16'h0000, seed_q};
                ISTS_OFS:
                begin
                    rdata_d = {29'h0, ists_q};
                    ists_d  = '0;
                end
                IMSK_OFS:  rdata_d = {29'h0, imsk_q};
                default:   rdata_d = 32'h0000_0000;
            endcase
        end

        case (state_q)
            MT_IDLE:
            begin
                // pause frames go ahead of data and ignore a received hold
                if (transmitter_enable_q && FULL_DUPLEX_I && (force_q || apend_q))
                begin
                    psend_d = 1'b1;
                    pman_d  = force_q;
                    // manual and on-threshold frames carry the programmed time
                    ptx_d   = (!force_q && azero_q) ? 16'h0000 : ptime_q;
                    if (!force_q)
                        apend_d = 1'b0;
                    state_d = MT_PAUSE;
                end
                else if (transmitter_enable_q && TXQ_VALID_I && !hold_q && bo_q == 10'h000)
                begin
                    start_d = 1'b1;
                    bad_d   = corrupt_checksum_enable_q;
                    state_d = MT_DATA;
                end
                else if (dis_q && !transmitter_enable_q)
                begin
                    dis_d      = 1'b0;
                    txd_d      = 1'b1;
                    ev[IRQ_TXD] = 1'b1;
                end
            end
            MT_DATA:
            begin
                // enable is not looked at here: the frame in flight runs until done or a half-duplex collision
                if (COLLISION_I && !FULL_DUPLEX_I)
                begin
                    collide   = 1'b1;
                    attempt_d = (attempt_q == ATTEMPT_MAX - 5'h01) ? 5'h00 : attempt_q + 5'h01;
                    state_d   = MT_IDLE;
                end
                else if (FRAME_DONE_I)
                begin
                    attempt_d = 5'h00;
                    state_d   = MT_IDLE;
                end
            end
            MT_PAUSE:
            begin
                if (FRAME_DONE_I)
                begin
                    if (pman_q)
                        force_d = 1'b0;
                    ev[IRQ_PSENT] = 1'b1;
                    state_d = MT_IDLE;
                end
            end
            default: state_d = MT_IDLE;
        endcase

        // a new request in the clearing cycle survives
        if (wr_flow && REG_WDATA_I[FORCE_BIT])
            force_d = 1'b1;

        if (txfc_q && FULL_DUPLEX_I)
        begin
            if (!hi_q && used_blk >= {8'h00, FC_ON_THR_I})
            begin
                hi_d    = 1'b1;
                apend_d = 1'b1;
                azero_d = 1'b0;
            end
            else if (hi_q && used_blk <= {8'h00, FC_OFF_THR_I})
            begin
                hi_d    = 1'b0;
                apend_d = 1'b1;
                azero_d = 1'b1;
            end
        end

        ev[IRQ_PRCV] = pause_load;
        // events win over a read clear in the same cycle
        ists_d = ists_d | ev;
        irq_d  = |(ists_d & imsk_d);
        dec_d  = rxfc_q && FULL_DUPLEX_I;
        fwd_d  = fpf_q;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            state_q   <= MT_IDLE;
            transmitter_enable_q    <= 1'b0;
            corrupt_checksum_enable_q    <= 1'b0;
            txd_q     <= 1'b0;
            dis_q     <= 1'b0;
            force_q   <= 1'b0;
            txfc_q    <= 1'b0;
            rxfc_q    <= 1'b0;
            fpf_q     <= 1'b0;
            ptime_q   <= PTIME_RST;
            seed_q    <= SEED_RST;
            imsk_q    <= '0;
            ists_q    <= '0;
            ptx_q     <= 16'h0000;
            bad_q     <= 1'b0;
            hi_q      <= 1'b0;
            apend_q   <= 1'b0;
            azero_q   <= 1'b0;
            pman_q    <= 1'b0;
            attempt_q <= 5'h00;
            rdata_q   <= 32'h0000_0000;
            start_q   <= 1'b0;
            psend_q   <= 1'b0;
            dec_q     <= 1'b0;
            fwd_q     <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            transmitter_enable_q    <= transmitter_enable_d;
            corrupt_checksum_enable_q    <= corrupt_checksum_enable_d;
            txd_q     <= txd_d;
            dis_q     <= dis_d;
            force_q   <= force_d;
            txfc_q    <= txfc_d;
            rxfc_q    <= rxfc_d;
            fpf_q     <= fpf_d;
            ptime_q   <= ptime_d;
            seed_q    <= seed_d;
            imsk_q    <= imsk_d;
            ists_q    <= ists_d;
            ptx_q     <= ptx_d;
            bad_q     <= bad_d;
            hi_q      <= hi_d;
            apend_q   <= apend_d;
            azero_q   <= azero_d;
            pman_q    <= pman_d;
            attempt_q <= attempt_d;
            rdata_q   <= rdata_d;
            start_q   <= start_d;
            psend_q   <= psend_d;
            dec_q     <= dec_d;
            fwd_q     <= fwd_d;
            irq_q     <= irq_d;
        end
    end

    // ---------------- slot timing, pause hold, back-off ----------------
    // one free-running slot tick serves both timers, so a wait may come up
    // to one slot short; cheaper than a phase counter per timer
    always_comb
    begin
        tick_d   = slot_end ? SLOT_LAST : tick_q - 7'h01;
        lfsr_d   = wr_seed ? REG_WDATA_I[15:0]
                           : {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        quanta_d = quanta_q;
        bo_d     = bo_q;
        bo_exp   = (attempt_q >= {1'b0, BO_LIMIT} - 5'h01) ? BO_LIMIT : 4'(attempt_q + 5'h01);
        if (!FULL_DUPLEX_I)
            quanta_d = 16'h0000;
        else if (pause_load)
            quanta_d = RX_PAUSE_QUANTA_I;
        else if (slot_end && quanta_q != 16'h0000)
            quanta_d = quanta_q - 16'h0001;
        if (collide)
            bo_d = lfsr_q[9:0] & (BO_FULL >> (BO_LIMIT - bo_exp));
        else if (slot_end && bo_q != 10'h000)
            bo_d = bo_q - 10'h001;
        hold_d = quanta_d != 16'h0000;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            tick_q   <= SLOT_LAST;
            lfsr_q   <= SEED_RST;
            quanta_q <= 16'h0000;
            bo_q     <= 10'h000;
            hold_q   <= 1'b0;
        end
        else
        begin
            tick_q   <= tick_d;
            lfsr_q   <= lfsr_d;
            quanta_q <= quanta_d;
            bo_q     <= bo_d;
            hold_q   <= hold_d;
        end
    end

    assign REG_RDATA_O        = rdata_q;
    assign TXQ_START_O        = start_q;
    assign BAD_FCS_O          = bad_q;
    assign PAUSE_SEND_O       = psend_q;
    assign PAUSE_TIME_O       = ptx_q;
    assign PAUSE_HOLD_O       = hold_q;
    assign RX_CTRL_DECODE_O   = dec_q;
    assign RX_PAUSE_FORWARD_O = fwd_q;
    assign IRQ_O              = irq_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    chk_bad_fcs_copy: assert property (start_q |-> bad_q == $past(corrupt_checksum_enable_q))
        else $error("bad fcs flag not taken from control bit");
    chk_start_needs_en: assert property (start_q |-> $past(transmitter_enable_q))
        else $error("frame started while transmitter disabled");
    chk_frame_finishes: assert property (
        (state_q == MT_DATA && !FRAME_DONE_I && !COLLISION_I) |=> state_q == MT_DATA)
        else $error("frame cut short");
    chk_txd_on_done: assert property (
        $rose(txd_q) |-> $past(dis_q) && $past(state_q) == MT_IDLE && !$past(transmitter_enable_q))
        else $error("disabled flag set outside disable completion");
    // a one-quantum pause may end right after loading, so the loaded count is checked instead
    chk_pause_hold: assert property (
        (pause_load && RX_PAUSE_QUANTA_I != 16'h0000)
        |=> hold_q && quanta_q == $past(RX_PAUSE_QUANTA_I))
        else $error("received pause did not hold transmitter");
    chk_no_decode_off: assert property (
        (!rxfc_q && !hold_q && !$past(rxfc_q)) |=> !hold_q && !dec_q)
        else $error("pause acted on while decode disabled");
    chk_force_clear: assert property (
        $fell(force_q) |-> $past(state_q) == MT_PAUSE && $past(FRAME_DONE_I) && $past(pman_q))
        else $error("manual pause bit cleared without a sent frame");
    chk_auto_on: assert property (
        (txfc_q && FULL_DUPLEX_I && !hi_q && used_blk >= {8'h00, FC_ON_THR_I})
        |=> hi_q && apend_q && !azero_q)
        else $error("high watermark did not request pause");
    chk_auto_off: assert property (
        (txfc_q && FULL_DUPLEX_I && hi_q && used_blk <= {8'h00, FC_OFF_THR_I})
        |=> !hi_q && apend_q && azero_q)
        else $error("low watermark did not request zero pause");
    chk_half_quiet: assert property (!FULL_DUPLEX_I |=> !psend_q && !hold_q)
        else $error("pause activity in half duplex");
    chk_manual_time: assert property (
        (psend_q && pman_q) |-> PAUSE_TIME_O == $past(ptime_q))
        else $error("manual pause frame time mismatch");
    chk_seed_load: assert property (wr_seed |=> lfsr_q == $past(REG_WDATA_I[15:0]))
        else $error("seed not loaded into shift register");
    chk_backoff_wait: assert property (start_q |-> $past(bo_q) == 10'h000)
        else $error("frame started during back-off");

    cov_manual_pause: cover property (wr_flow && REG_WDATA_I[FORCE_BIT] ##[1:60] $fell(force_q));
    cov_auto_cycle: cover property ($rose(hi_q) ##[1:200] $fell(hi_q));
    cov_graceful_off: cover property (state_q == MT_DATA && !transmitter_enable_q ##[1:50] $rose(txd_q));
    cov_collision: cover property (collide ##1 bo_q != 10'h000);
endmodule : mtpc_top

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top
    import mtpc_pkg::*;
;
    logic        clk        = 1'b0;
    logic        rst_n      = 1'b0;
    logic [11:0] addr       = 12'h000;
    logic [31:0] wdata      = 32'h00000000;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic        fdx        = 1'b1;
    logic        txq_valid  = 1'b0;
    logic [15:0] rx_used    = 16'h0000;
    logic [7:0]  on_thr     = 8'h04;
    logic [7:0]  off_thr    = 8'h01;
    logic        rxp_valid  = 1'b0;
    logic        coll       = 1'b0;
    logic [15:0] rxp_quanta = 16'h0000;
    logic [7:0]  m_delay    = 8'h03;
    logic [31:0] rdata;
    logic        frame_done, start, bad_fcs, psend, phold, decode, fwd, irq, busy, m_bad;
    logic [15:0] ptime, m_ptime;
    int          starts, pauses;
    int          err_total   = 0;
    int          checks_done = 0;

    always #20 clk = ~clk;

    mtpc_top uut (.CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .FULL_DUPLEX_I(fdx),
        .TXQ_VALID_I(txq_valid), .FRAME_DONE_I(frame_done), .COLLISION_I(coll),
        .RX_USED_I(rx_used), .FC_ON_THR_I(on_thr), .FC_OFF_THR_I(off_thr),
        .RX_PAUSE_VALID_I(rxp_valid), .RX_PAUSE_QUANTA_I(rxp_quanta), .TXQ_START_O(start),
        .BAD_FCS_O(bad_fcs), .PAUSE_SEND_O(psend), .PAUSE_TIME_O(ptime),
        .PAUSE_HOLD_O(phold), .RX_CTRL_DECODE_O(decode), .RX_PAUSE_FORWARD_O(fwd),
        .IRQ_O(irq));

    mtpc_phy_model phy (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .pause_i(psend),
        .ptime_i(ptime), .bad_fcs_i(bad_fcs), .delay_i(m_delay), .done_o(frame_done),
        .busy_o(busy), .starts_o(starts), .pauses_o(pauses), .ptime_o(m_ptime),
        .bad_o(m_bad));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
        checks_done++;
        if (act !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, act);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask : rd_chk

    // bounded wait for the line model to become busy or idle
    task automatic wait_busy(input logic lvl);
        int n = 0;
        while (busy !== lvl && n < 400)
        begin
            cyc(1);
            n++;
        end
        chk("model busy", 32'(lvl), 32'(busy));
    endtask : wait_busy

    task automatic t_regs;
        rd_chk("tx control reset", TXCTL_OFS, 32'h00000000);
        rd_chk("pause control reset", FLOW_OFS, 32'h00000000);
        rd_chk("seed reset", SEED_OFS, 32'(SEED_RST));
        wr_reg(SEED_OFS, 32'hFFFF1357);
        rd_chk("seed written", SEED_OFS, 32'h00001357);
        wr_reg(12'h1FC, 32'hFFFFFFFF);
        rd_chk("unmapped read", 12'h1FC, 32'h00000000);
        $display("test regs finished");
    endtask : t_regs

    task automatic t_enable;
        m_delay <= 8'h28;
        txq_valid <= 1'b1;
        cyc(20);
        chk("starts while disabled", 0, starts);
        wr_reg(TXCTL_OFS, 32'h00000005);
        wait_busy(1'b1);
        chk("frame started", 1, starts);
        chk("corrupt checksum", 1, 32'(m_bad));
        wr_reg(TXCTL_OFS, 32'h00000004);
        rd_chk("disabled flag mid frame", TXCTL_OFS, 32'h00000004);
        wait_busy(1'b0);
        cyc(4);
        rd_chk("disabled flag set", TXCTL_OFS, 32'h00000006);
        chk("no start after disable", 1, starts);
        wr_reg(IMSK_OFS, 32'h00000001);
        cyc(2);
        chk("irq raised", 1, 32'(irq));
        rd_chk("status tx disabled", ISTS_OFS, 32'h00000001);
        cyc(2);
        chk("irq cleared", 0, 32'(irq));
        wr_reg(TXCTL_OFS, 32'h00000002);
        rd_chk("disabled flag cleared", TXCTL_OFS, 32'h00000000);
        txq_valid <= 1'b0;
        m_delay <= 8'h03;
        $display("test enable finished");
    endtask : t_enable

    task automatic t_manual;
        wr_reg(TXCTL_OFS, 32'h00000001);
        fdx <= 1'b0;
        wr_reg(FLOW_OFS, 32'h80001234);
        cyc(20);
        chk("pause in half duplex", 0, pauses);
        @(posedge clk);
        fdx <= 1'b1;
        wait_busy(1'b1);
        chk("manual pause time", 32'h00001234, 32'(m_ptime));
        wait_busy(1'b0);
        cyc(3);
        rd_chk("manual bit self clear", FLOW_OFS, 32'h00001234);
        chk("one manual pause", 1, pauses);
        rd_chk("status pause sent", ISTS_OFS, 32'h00000002);
        $display("test manual finished");
    endtask : t_manual

    task automatic t_auto;
        wr_reg(FLOW_OFS, 32'h400000AB);
        @(posedge clk);
        rx_used <= 16'h07FF;
        cyc(20);
        chk("below on threshold", 1, pauses);
        @(posedge clk);
        rx_used <= 16'h0800;
        wait_busy(1'b1);
        chk("auto pause time", 32'h000000AB, 32'(m_ptime));
        wait_busy(1'b0);
        @(posedge clk);
        rx_used <= 16'h0400;
        cyc(20);
        chk("above off threshold", 2, pauses);
        @(posedge clk);
        rx_used <= 16'h03FF;
        wait_busy(1'b1);
        chk("zero pause time", 32'h00000000, 32'(m_ptime));
        wait_busy(1'b0);
        wr_reg(FLOW_OFS, 32'h00000000);
        $display("test auto finished");
    endtask : t_auto

    task automatic pulse_pause(input logic [15:0] q);
        @(posedge clk);
        rxp_valid  <= 1'b1;
        rxp_quanta <= q;
        @(posedge clk);
        rxp_valid <= 1'b0;
    endtask : pulse_pause

    task automatic t_rxpause;
        int n = 0;
        wr_reg(FLOW_OFS, 32'h30000000);
        cyc(2);
        chk("decode on", 1, 32'(decode));
        chk("forward on", 1, 32'(fwd));
        pulse_pause(16'h0002);
        cyc(1);
        chk("hold raised", 1, 32'(phold));
        rd_chk("status pause received", ISTS_OFS, 32'h00000006);
        txq_valid <= 1'b1;
        cyc(100);
        chk("no start while held", 1, starts);
        while (phold === 1'b1 && n < 300)
        begin
            cyc(1);
            n++;
        end
        chk("hold released", 0, 32'(phold));
        wait_busy(1'b1);
        chk("start after hold", 2, starts);
        chk("good checksum", 0, 32'(m_bad));
        txq_valid <= 1'b0;
        wait_busy(1'b0);
        wr_reg(FLOW_OFS, 32'h00000000);
        cyc(2);
        chk("decode off", 0, 32'(decode));
        chk("forward off", 0, 32'(fwd));
        pulse_pause(16'h0002);
        cyc(2);
        chk("no hold when off", 0, 32'(phold));
        $display("test rx pause finished");
    endtask : t_rxpause

    // half duplex: a collision on the first attempt backs off zero or one slot
    task automatic t_collide;
        int n = 0;
        fdx       <= 1'b0;
        txq_valid <= 1'b1;
        wait_busy(1'b1);
        @(posedge clk);
        coll <= 1'b1;
        @(posedge clk);
        coll <= 1'b0;
        while (start !== 1'b1 && n < 300)
        begin
            cyc(1);
            n++;
        end
        chk("retry within one slot", 1, 32'(n <= 132));
        txq_valid <= 1'b0;
        cyc(20);
        fdx <= 1'b1;
        $display("test collision finished");
    endtask : t_collide

    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_enable();
        t_manual();
        t_auto();
        t_rxpause();
        t_collide();
        stop_test();
    end

    // the tests need under a thousand cycles; this bound only cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule : tb_top
